/* inc/ppc_pkg.sv */
// ppc_pkg: constants and carrier types for the two-channel command-slot driver
// assumes: one system clock, PHY command inputs sampled on that clock
package ppc_pkg;

  // slot format: eight interface bits per dram pin, four dram clocks
  localparam int SLOT_BITS = 8;
  localparam int SLOTS = 4;
  localparam int NUM_CHANNELS = 2;
  localparam int MAX_RANKS = 2;
  localparam int MAX_TOTAL_DQ = 64;
  localparam int BYTE_BITS = 8;

  // address field positions (ddr4 strobe functions on upper address bytes)
  localparam int ADDR_PINS = 17;
  localparam int DDR4_WE_PIN = 14;
  localparam int DDR4_CAS_PIN = 15;
  localparam int DDR4_RAS_PIN = 16;

  // idle levels of a slot byte
  localparam logic [7:0] SLOT_HIGH = 8'hff;
  localparam logic [7:0] SLOT_LOW = 8'h00;
  // column commands allowed in slot zero and slot two only
  localparam logic [1:0] CAS_SLOT_A = 2'h0;
  localparam logic [1:0] CAS_SLOT_B = 2'h2;

  typedef enum logic [1:0] {
    PPC_CMD_NOP,
    PPC_CMD_ACT,
    PPC_CMD_RD,
    PPC_CMD_WR
  } ppc_cmd_kind_t;

  typedef enum logic [1:0] {
    PPC_CMD_PRE = 2'h0,
    PPC_CMD_REF = 2'h1,
    PPC_CMD_MRS = 2'h2,
    PPC_CMD_ZQ = 2'h3
  } ppc_misc_kind_t;

  // one user command for one slot
  typedef struct packed {
    logic valid;
    logic misc;
    ppc_cmd_kind_t kind;
    ppc_misc_kind_t misc_kind;
    logic channel;
    logic rank;
    logic [ADDR_PINS-1:0] addr;
  } ppc_cmd_t;

endpackage : ppc_pkg

/* verilog/ppc_slot_pin.sv */
// ppc_slot_pin: expands four per-slot levels of one dram pin into its slot byte
// assumes: slot n occupies bits 2n+1:2n; 1n timing so both bits match
module ppc_slot_pin import ppc_pkg::*; (
  // slot levels, index = slot number
  input wire logic [SLOTS-1:0] i_level,
  // eight-bit slot byte
  output logic [SLOT_BITS-1:0] o_byte
);

  // each slot pair driven to one value for centre alignment
  always_comb begin
    for (int s = 0; s < SLOTS; s++) begin
      o_byte[2*s +: 2] = {2{i_level[s]}};
    end
  end

endmodule : ppc_slot_pin

/* verilog/ppc_pin_group.sv */
// ppc_pin_group: a vector of dram pins, each expanded into its slot byte
// assumes: pin p's levels arrive as bits [p*SLOTS +: SLOTS]
module ppc_pin_group import ppc_pkg::*; #(
  parameter int PINS = 1
) (
  // per-pin, per-slot levels
  input wire logic [PINS*SLOTS-1:0] i_levels,
  // one byte per pin, lowest byte = pin zero
  output logic [PINS*SLOT_BITS-1:0] o_bytes
);

  initial begin
    if (PINS < 1) $error("ppc_pin_group needs at least one pin");
  end

  // lowest byte feeds pin zero, upward
  for (genvar p = 0; p < PINS; p++) begin : g_pin
    ppc_slot_pin u_pin (
      .i_level(i_levels[p*SLOTS +: SLOTS]),
      .o_byte(o_bytes[p*SLOT_BITS +: SLOT_BITS])
    );
  end

endmodule : ppc_pin_group

/* verilog/ppc_cmd_driver.sv */
// ppc_cmd_driver: user-side controller that builds slotted command words
// for a two-channel phy sharing command/address pins.
// assumes: phy samples all o_ slot words every i_sys_clk edge; user holds
// i_cmd stable while o_cmd_ready is low.
module ppc_cmd_driver import ppc_pkg::*; #(
  parameter int RANKS = 1,
  parameter int DQ_WIDTH = 64,
  parameter int DEVICE_WIDTH = 8,
  parameter int ADDR_WIDTH = ADDR_PINS,
  parameter int CKE_COUNT = 1,
  parameter int TERMINATION_COUNT = 1,
  parameter bit IS_DDR4 = 1'b1,
  parameter bit SHARED_CKE = 1'b0,
  parameter int GAP_SLOTS = 4
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // user command port
  input wire ppc_cmd_t i_cmd,
  input wire logic [1:0] i_cmd_slot,
  input wire logic [NUM_CHANNELS*CKE_COUNT-1:0] i_cke_level,
  input wire logic [NUM_CHANNELS*TERMINATION_COUNT-1:0] i_odt_level,
  output logic o_cmd_ready,
  output logic o_cmd_taken,
  output logic o_cmd_error,
  // slotted phy command/address inputs
  output logic [SLOT_BITS-1:0] o_activate_n_slots,
  output logic [ADDR_WIDTH*SLOT_BITS-1:0] o_address_slots,
  output logic [SLOT_BITS-1:0] o_row_strobe_slots,
  output logic [SLOT_BITS-1:0] o_column_strobe_slots,
  output logic [SLOT_BITS-1:0] o_write_enable_slots,
  output logic [NUM_CHANNELS*RANKS*SLOT_BITS-1:0] o_chip_select_slots,
  output logic [NUM_CHANNELS*CKE_COUNT*SLOT_BITS-1:0] o_clock_enable_slots,
  output logic [NUM_CHANNELS*TERMINATION_COUNT*SLOT_BITS-1:0] o_termination_slots
);

  localparam int CH_WIDTH = DQ_WIDTH / NUM_CHANNELS;
  localparam int CS_PINS = NUM_CHANNELS * RANKS;
  localparam int CKE_PINS = NUM_CHANNELS * CKE_COUNT;
  localparam int ODT_PINS = NUM_CHANNELS * TERMINATION_COUNT;

  // configuration checks refuse what the phy cannot serve
  initial begin
    if (RANKS < 1 || RANKS > MAX_RANKS) $error("ranks must be 1 or 2");
    if (DEVICE_WIDTH != 4 && DEVICE_WIDTH != 8 && DEVICE_WIDTH != 16)
      $error("device width must be 4, 8 or 16");
    if (CH_WIDTH % BYTE_BITS != 0 || DQ_WIDTH % NUM_CHANNELS != 0)
      $error("channel width must be a multiple of eight");
    if (DQ_WIDTH > MAX_TOTAL_DQ || DQ_WIDTH < 2 * BYTE_BITS)
      $error("total width out of range");
    if (DEVICE_WIDTH == 16 && DQ_WIDTH != 32 && DQ_WIDTH != 64)
      $error("x16 only at total widths 32 and 64");
    if (ADDR_WIDTH < ADDR_PINS) $error("address too narrow for strobe bytes");
    if (CKE_COUNT != RANKS && CKE_COUNT != 1) $error("bad clock enable count");
    if (TERMINATION_COUNT < 1 || TERMINATION_COUNT > RANKS)
      $error("bad termination count");
    if (GAP_SLOTS < 1 || GAP_SLOTS > 255) $error("bad gap");
  end

  // per-slot pin levels assembled during one word
  logic [SLOTS-1:0] act_lv, ras_lv, cas_lv, we_lv;
  logic [ADDR_WIDTH*SLOTS-1:0] addr_lv;
  logic [CS_PINS*SLOTS-1:0] cs_lv;
  logic [CKE_PINS*SLOTS-1:0] cke_lv;
  logic [ODT_PINS*SLOTS-1:0] odt_lv;

  // one word carries a single command in one of slots 0..3, then an emit cycle follows
  typedef enum {
    PPC_ST_COLLECT,
    PPC_ST_EMIT
  } ppc_state_t;
  ppc_state_t state;
  logic [7:0] gap_cnt [NUM_CHANNELS];
  logic cmd_ok;
  logic [2:0] cmd_pins;

  // decode the dram pin triple ras/cas/we (active low) per command
  always_comb begin
    cmd_pins = 3'h7;
    if (i_cmd.misc) begin
      case (i_cmd.misc_kind)
        PPC_CMD_PRE: cmd_pins = 3'h2;
        PPC_CMD_REF: cmd_pins = 3'h1;
        PPC_CMD_MRS: cmd_pins = 3'h0;
        PPC_CMD_ZQ: cmd_pins = 3'h6;
        default: cmd_pins = 3'h7;
      endcase
    end else begin
      case (i_cmd.kind)
        PPC_CMD_ACT: cmd_pins = 3'h3;
        PPC_CMD_RD: cmd_pins = 3'h5;
        PPC_CMD_WR: cmd_pins = 3'h4;
        default: cmd_pins = 3'h7;
      endcase
    end
  end

  // column commands only in slot 0 or 2; channel must have spent its gap
  always_comb begin
    cmd_ok = 1'b1;
    if (!i_cmd.misc && (i_cmd.kind == PPC_CMD_RD || i_cmd.kind == PPC_CMD_WR) &&
        i_cmd_slot != CAS_SLOT_A && i_cmd_slot != CAS_SLOT_B)
      cmd_ok = 1'b0;
    if (gap_cnt[i_cmd.channel] != 8'h00)
      cmd_ok = 1'b0;
    if (RANKS == 1 && i_cmd.rank)
      cmd_ok = 1'b0;
  end

  // collect/emit sequencing and handshake flags
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= PPC_ST_COLLECT;
      o_cmd_ready <= 1'b0;
      o_cmd_taken <= 1'b0;
      o_cmd_error <= 1'b0;
    end else begin
      o_cmd_taken <= 1'b0;
      o_cmd_error <= 1'b0;
      case (state)
        PPC_ST_COLLECT: begin
          o_cmd_ready <= 1'b1;
          if (o_cmd_ready && i_cmd.valid) begin
            o_cmd_taken <= cmd_ok;
            o_cmd_error <= !cmd_ok;
            if (cmd_ok) begin
              state <= PPC_ST_EMIT;
              o_cmd_ready <= 1'b0;
            end
          end
        end
        PPC_ST_EMIT: begin
          state <= PPC_ST_COLLECT;
          o_cmd_ready <= 1'b1;
        end
        default: state <= PPC_ST_COLLECT;
      endcase
    end
  end

  // per-channel spacing counters, loaded by a command to that channel
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      gap_cnt[0] <= 8'h00;
      gap_cnt[1] <= 8'h00;
    end else begin
      for (int c = 0; c < NUM_CHANNELS; c++) begin
        if (state == PPC_ST_COLLECT && o_cmd_ready && i_cmd.valid && cmd_ok &&
            i_cmd.channel == c[0])
          gap_cnt[c] <= 8'(GAP_SLOTS);
        else if (gap_cnt[c] != 8'h00)
          gap_cnt[c] <= gap_cnt[c] - 8'h01;
      end
    end
  end

  // slot levels: idle everywhere, the taken command in its own slot
  always_comb begin
    act_lv = '1;
    ras_lv = '1;
    cas_lv = '1;
    we_lv = '1;
    addr_lv = '0;
    cs_lv = '1;
    cke_lv = '0;
    odt_lv = '0;
    for (int s = 0; s < SLOTS; s++) begin
      for (int p = 0; p < CKE_PINS; p++) begin
        // shared enable: channel one copies channel zero's bit zero
        if (SHARED_CKE && p >= CKE_COUNT)
          cke_lv[p*SLOTS+s] = i_cke_level[0];
        else
          cke_lv[p*SLOTS+s] = i_cke_level[p];
      end
      for (int p = 0; p < ODT_PINS; p++)
        odt_lv[p*SLOTS+s] = i_odt_level[p];
    end
    // only an accepted command reaches the pins, never one held during emit
    if (state == PPC_ST_COLLECT && o_cmd_ready && i_cmd.valid && cmd_ok) begin
      for (int a = 0; a < ADDR_WIDTH; a++)
        addr_lv[a*SLOTS + int'(i_cmd_slot)] = i_cmd.addr[a];
      // only the targeted channel and rank selected
      cs_lv[(int'(i_cmd.channel)*RANKS + int'(i_cmd.rank))*SLOTS + int'(i_cmd_slot)] = 1'b0;
      if (IS_DDR4) begin
        if (!i_cmd.misc && i_cmd.kind == PPC_CMD_ACT) begin
          act_lv[i_cmd_slot] = 1'b0;
        end else begin
          addr_lv[DDR4_RAS_PIN*SLOTS + int'(i_cmd_slot)] = cmd_pins[2];
          addr_lv[DDR4_CAS_PIN*SLOTS + int'(i_cmd_slot)] = cmd_pins[1];
          addr_lv[DDR4_WE_PIN*SLOTS + int'(i_cmd_slot)] = cmd_pins[0];
        end
      end else begin
        ras_lv[i_cmd_slot] = cmd_pins[2];
        cas_lv[i_cmd_slot] = cmd_pins[1];
        we_lv[i_cmd_slot] = cmd_pins[0];
      end
    end
  end

  // byte expansion of every pin group
  logic [SLOT_BITS-1:0] act_b, ras_b, cas_b, we_b;
  logic [ADDR_WIDTH*SLOT_BITS-1:0] addr_b;
  logic [CS_PINS*SLOT_BITS-1:0] cs_b;
  logic [CKE_PINS*SLOT_BITS-1:0] cke_b;
  logic [ODT_PINS*SLOT_BITS-1:0] odt_b;

  ppc_pin_group #(.PINS(1)) u_act (.i_levels(act_lv), .o_bytes(act_b));
  ppc_pin_group #(.PINS(1)) u_ras (.i_levels(ras_lv), .o_bytes(ras_b));
  ppc_pin_group #(.PINS(1)) u_cas (.i_levels(cas_lv), .o_bytes(cas_b));
  ppc_pin_group #(.PINS(1)) u_we (.i_levels(we_lv), .o_bytes(we_b));
  ppc_pin_group #(.PINS(ADDR_WIDTH)) u_addr (.i_levels(addr_lv), .o_bytes(addr_b));
  ppc_pin_group #(.PINS(CS_PINS)) u_cs (.i_levels(cs_lv), .o_bytes(cs_b));
  ppc_pin_group #(.PINS(CKE_PINS)) u_cke (.i_levels(cke_lv), .o_bytes(cke_b));
  ppc_pin_group #(.PINS(ODT_PINS)) u_odt (.i_levels(odt_lv), .o_bytes(odt_b));

  // registered slot words; idle word when no command is taken
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_activate_n_slots <= SLOT_HIGH;
      o_row_strobe_slots <= SLOT_HIGH;
      o_column_strobe_slots <= SLOT_HIGH;
      o_write_enable_slots <= SLOT_HIGH;
      o_address_slots <= '0;
      o_chip_select_slots <= '1;
      o_clock_enable_slots <= '0;
      o_termination_slots <= '0;
    end else begin
      // activate byte kept high on ddr3, where the phy ignores it
      o_activate_n_slots <= IS_DDR4 ? act_b : SLOT_HIGH;
      o_row_strobe_slots <= ras_b;
      o_column_strobe_slots <= cas_b;
      o_write_enable_slots <= we_b;
      o_address_slots <= addr_b;
      o_clock_enable_slots <= cke_b;
      o_termination_slots <= odt_b;
      if (state == PPC_ST_COLLECT && o_cmd_ready && i_cmd.valid && cmd_ok)
        o_chip_select_slots <= cs_b;
      else
        o_chip_select_slots <= '1;
    end
  end

  // data lane placement is a board/phy matter; CH_WIDTH only checked
endmodule : ppc_cmd_driver

/* tb/ppc_cmd_driver_asserts.sv */
// checker: slot-word relations at the command driver ports
// assumes: bound into ppc_cmd_driver, one clock, async active-low reset
module ppc_cmd_driver_asserts import ppc_pkg::*; #(
  parameter int RANKS = 1,
  parameter int CKE_COUNT = 1,
  parameter int TERMINATION_COUNT = 1,
  parameter bit IS_DDR4 = 1'b1,
  parameter bit SHARED_CKE = 1'b0
) (
  // clock, reset and user side
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire ppc_cmd_t i_cmd,
  input wire logic [1:0] i_cmd_slot,
  input wire logic [NUM_CHANNELS*CKE_COUNT-1:0] i_cke_level,
  input wire logic [NUM_CHANNELS*TERMINATION_COUNT-1:0] i_odt_level,
  input wire logic o_cmd_ready,
  input wire logic o_cmd_taken,
  input wire logic o_cmd_error,
  // slot words
  input wire logic [SLOT_BITS-1:0] o_activate_n_slots,
  input wire logic [SLOT_BITS-1:0] o_row_strobe_slots,
  input wire logic [SLOT_BITS-1:0] o_column_strobe_slots,
  input wire logic [SLOT_BITS-1:0] o_write_enable_slots,
  input wire logic [NUM_CHANNELS*RANKS*SLOT_BITS-1:0] o_chip_select_slots,
  input wire logic [NUM_CHANNELS*CKE_COUNT*SLOT_BITS-1:0] o_clock_enable_slots,
  input wire logic [NUM_CHANNELS*TERMINATION_COUNT*SLOT_BITS-1:0] o_termination_slots
);
  localparam int CSW = RANKS * SLOT_BITS;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  // column command aimed at an odd slot, and the idle chip-select word
  logic col_odd;
  logic cs_idle;
  assign col_odd = i_cmd.valid && !i_cmd.misc && i_cmd_slot[0] && i_cmd.kind[1];
  assign cs_idle = &o_chip_select_slots;
  // both bits of every slot pair equal
  function automatic bit pairs_ok(logic [7:0] b);
    return b[0] == b[1] && b[2] == b[3] && b[4] == b[5] && b[6] == b[7];
  endfunction : pairs_ok
  taken_ready_a: assert property (o_cmd_taken |-> !o_cmd_ready ##1 o_cmd_ready)
    else $error("ready not back one cycle after a take");
  idle_after_a: assert property (o_cmd_taken |=> cs_idle && !o_cmd_taken)
    else $error("slot word not idle after a command");
  cas_slot_a: assert property (o_cmd_ready && col_odd |=> o_cmd_error && cs_idle)
    else $error("column command in odd slot not refused");
  rank_refuse_a: assert property (o_cmd_ready && i_cmd.valid && i_cmd.rank && RANKS == 1
    |=> o_cmd_error)
    else $error("second rank not refused");
  slot_pairs_a: assert property (pairs_ok(o_activate_n_slots) && pairs_ok(o_chip_select_slots[7:0])
    && pairs_ok(o_chip_select_slots[CSW +: 8]))
    else $error("slot pair bits differ");
  one_channel_a: assert property (&(o_chip_select_slots[0 +: CSW]
    | o_chip_select_slots[CSW +: CSW]))
    else $error("both channels selected in one slot");
  cs_on_take_a: assert property (o_cmd_taken |-> !cs_idle)
    else $error("command without chip select");
  error_idle_a: assert property (o_cmd_error |-> cs_idle && &o_activate_n_slots)
    else $error("refused command reached the pins");
  shared_cke_a: assert property (SHARED_CKE |=> o_clock_enable_slots[CKE_COUNT*8 +: 8]
    == {8{$past(i_cke_level[0])}})
    else $error("channel one clock enable not following bit zero");
  termination_a: assert property (1'b1 |=> o_termination_slots[7:0] == {8{$past(i_odt_level[0])}}
    && o_termination_slots[TERMINATION_COUNT*8 +: 8]
    == {8{$past(i_odt_level[TERMINATION_COUNT])}})
    else $error("termination slot word wrong");
  ddr4_strobes_a: assert property (IS_DDR4 |-> &{o_row_strobe_slots, o_column_strobe_slots,
    o_write_enable_slots})
    else $error("strobe inputs driven on ddr4");
  // main scenarios reached
  cover property (o_cmd_taken && !(&o_activate_n_slots));
  cover property (o_cmd_error);
  cover property ($rose(o_clock_enable_slots[CKE_COUNT*8]));
endmodule : ppc_cmd_driver_asserts

/* tb/ppc_phy_model.sv */
// ppc_phy_model: behavioural two-channel phy decoding the slotted word
// assumes: ddr4, one rank, 1n timing; o_bad counts slots it cannot take
module ppc_phy_model import ppc_pkg::*; (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // slotted inputs from the controller
  input wire logic [7:0] i_act_n,
  input wire logic [ADDR_PINS*8-1:0] i_adr,
  input wire logic [15:0] i_cs_n,
  // decoded command of the selected slot
  output logic [1:0] o_hit,
  output logic [ADDR_PINS-1:0] o_addr,
  output int o_bad
);
  timeunit 1ns;
  timeprecision 1ns;
  // shared pins: only chip select tells the channels apart; rank one never decoded
  always_comb begin
    o_hit = 2'h0;
    o_addr = '0;
    for (int s = 0; s < SLOTS; s++) begin
      if (!(i_cs_n[2*s] && i_cs_n[8+2*s])) begin
        o_hit = {!i_cs_n[8+2*s], !i_cs_n[2*s]};
        for (int p = 0; p < ADDR_PINS; p++) o_addr[p] = i_adr[8*p+2*s];
      end
    end
  end
  // split pairs, two channels at once or an odd-slot column command are not taken
  always @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_bad = 0;
    end else begin
      for (int s = 0; s < SLOTS; s++) begin
        if (i_cs_n[2*s] != i_cs_n[2*s+1] || i_cs_n[8+2*s] != i_cs_n[9+2*s]
            || i_act_n[2*s] != i_act_n[2*s+1] || !(i_cs_n[2*s] || i_cs_n[8+2*s])
            || (s % 2 == 1 && !(i_cs_n[2*s] && i_cs_n[8+2*s]) && i_act_n[2*s]
            && i_adr[128+2*s] && !i_adr[120+2*s])) begin
          o_bad = o_bad + 1;
        end
      end
    end
  end
endmodule : ppc_phy_model

/* tb/ppc_cmd_driver_tb.sv */
// ppc_cmd_driver_tb: table of single commands, then spacing, cke sharing, reset
// assumes: ddr4, one rank, shared cke, GAP_SLOTS 4; the phy model decodes words
module ppc_cmd_driver_tb import ppc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // one row: command, slot, refusal expected
  typedef struct packed {
    ppc_cmd_t cmd;
    logic [1:0] slot;
    logic err;
  } ppc_row_t;
  logic i_sys_clk = 1'b0;
  logic i_resetn = 1'b0;
  ppc_cmd_t i_cmd = '0;
  logic [1:0] i_cmd_slot = 2'h0;
  logic [1:0] i_cke_level = 2'h3;
  logic [1:0] i_odt_level = 2'h1;
  logic o_cmd_ready, o_cmd_taken, o_cmd_error;
  logic [7:0] o_activate_n_slots, o_row_strobe_slots, o_column_strobe_slots, o_write_enable_slots;
  logic [ADDR_PINS*8-1:0] o_address_slots;
  logic [15:0] o_chip_select_slots, o_clock_enable_slots, o_termination_slots;
  logic [1:0] hit;
  logic [ADDR_PINS-1:0] addr;
  int bad, num_errors = 0, compares = 0, cyc = 0;
  ppc_row_t rows [11];
  // default x8 devices, 64 bits split evenly
  ppc_cmd_driver #(.SHARED_CKE(1'b1)) dut (.*);
  ppc_phy_model phy (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_act_n(o_activate_n_slots),
    .i_adr(o_address_slots), .i_cs_n(o_chip_select_slots), .o_hit(hit), .o_addr(addr),
    .o_bad(bad));
  always #50 i_sys_clk = ~i_sys_clk;
  // hang guard; the run needs about 120 cycles
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (exp !== got) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask : chk
  function automatic ppc_row_t mk(logic m, ppc_cmd_kind_t k, ppc_misc_kind_t mkd, logic ch,
      logic rk, logic [1:0] s, logic e);
    mk.cmd = '{1'b1, m, k, mkd, ch, rk, 17'h1a5c3};
    mk.slot = s;
    mk.err = e;
  endfunction : mk
  // strobe triple carried on address pins 16..14
  function automatic logic [2:0] triple(ppc_cmd_t c);
    logic [11:0] m;
    m = 12'b110_000_001_010;
    if (!c.misc) return (c.kind == PPC_CMD_RD) ? 3'b101 : 3'b100;
    return m[3*c.misc_kind +: 3];
  endfunction : triple
  // wait for ready, offer for one accepting edge, look at the settled answer
  task automatic run_row(ppc_row_t r, int idle);
    logic [7:0] cs;
    int n;
    n = 0;
    cs = r.err ? 8'hff : ~(8'h03 << (2 * r.slot));
    while (o_cmd_ready !== 1'b1 && n < 20) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    @(posedge i_sys_clk);
    i_cmd <= r.cmd;
    i_cmd_slot <= r.slot;
    @(posedge i_sys_clk);
    i_cmd.valid <= 1'b0;
    #1;
    chk("taken", !r.err, o_cmd_taken);
    chk("error", r.err, o_cmd_error);
    chk("cs", r.cmd.channel ? {cs, 8'hff} : {8'hff, cs}, o_chip_select_slots);
    chk("act", (!r.cmd.misc && r.cmd.kind == PPC_CMD_ACT) ? cs : 8'hff, o_activate_n_slots);
    chk("strobes", 32'hffffff,
      {o_row_strobe_slots, o_column_strobe_slots, o_write_enable_slots});
    if (!r.err) chk("hit", r.cmd.channel ? 2'h2 : 2'h1, hit);
    if (!r.err && !r.cmd.misc && r.cmd.kind == PPC_CMD_ACT) chk("addr", r.cmd.addr, addr);
    else if (!r.err) chk("pins", triple(r.cmd), addr[16:14]);
    repeat (idle) @(posedge i_sys_clk);
    #1;
  endtask : run_row
  initial begin
    rows = '{mk(0, PPC_CMD_ACT, PPC_CMD_PRE, 0, 0, 0, 0), mk(0, PPC_CMD_RD, PPC_CMD_PRE, 1, 0, 2, 0),
      mk(0, PPC_CMD_WR, PPC_CMD_PRE, 0, 0, 0, 0), mk(0, PPC_CMD_RD, PPC_CMD_PRE, 0, 0, 1, 1),
      mk(0, PPC_CMD_WR, PPC_CMD_PRE, 1, 0, 3, 1), mk(1, PPC_CMD_NOP, PPC_CMD_PRE, 1, 0, 1, 0),
      mk(1, PPC_CMD_NOP, PPC_CMD_REF, 0, 0, 3, 0), mk(1, PPC_CMD_NOP, PPC_CMD_MRS, 1, 0, 2, 0),
      mk(1, PPC_CMD_NOP, PPC_CMD_ZQ, 0, 0, 1, 0), mk(0, PPC_CMD_ACT, PPC_CMD_PRE, 1, 1, 3, 1),
      mk(0, PPC_CMD_ACT, PPC_CMD_PRE, 1, 0, 3, 0)};
    repeat (3) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    #1;
    foreach (rows[k]) run_row(rows[k], 6);
    // same channel too soon is refused, the other channel is free at once
    run_row(rows[0], 0);
    run_row(mk(0, PPC_CMD_ACT, PPC_CMD_PRE, 0, 0, 2, 1), 0);
    run_row(rows[1], 6);
    // shared clock enable follows bit zero only; termination per channel
    @(posedge i_sys_clk);
    i_cke_level <= 2'b01;
    i_odt_level <= 2'b10;
    @(posedge i_sys_clk);
    #1;
    chk("cke", 16'hffff, o_clock_enable_slots);
    chk("odt", 16'hff00, o_termination_slots);
    @(posedge i_sys_clk);
    i_cke_level <= 2'b10;
    @(posedge i_sys_clk);
    #1;
    chk("cke", 16'h0000, o_clock_enable_slots);
    // the phy model clears its fault count on reset, so read it first
    chk("phy faults", 0, bad);
    // reset in mid-run drops every chip select
    @(posedge i_sys_clk);
    i_resetn <= 1'b0;
    #1;
    chk("reset cs", 16'hffff, o_chip_select_slots);
    chk("reset ready", 0, o_cmd_ready);
    repeat (3) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    #1;
    chk("ready", 1, o_cmd_ready);
    chk("phy faults after reset", 0, bad);
    finish_test();
  end
endmodule : ppc_cmd_driver_tb
bind ppc_cmd_driver ppc_cmd_driver_asserts #(.RANKS(RANKS), .CKE_COUNT(CKE_COUNT),
  .TERMINATION_COUNT(TERMINATION_COUNT), .IS_DDR4(IS_DDR4), .SHARED_CKE(SHARED_CKE)) u_chk (.*);
